// ==== hw/rsa_alarm_stamp.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsa_alarm_stamp
  import rsa_pkg::*;
#(
  parameter int PULSE_CYCLES = RSA_PULSE_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] cal_seconds_i,
  input wire logic [7:0] cal_minutes_i,
  input wire logic [7:0] cal_hours_i,
  input wire logic [7:0] cal_date_i,
  input wire logic [7:0] cal_month_i,
  input wire logic [7:0] cal_weekday_i,
  input wire logic cal_advance_i,
  input wire logic on_battery_i,
  input wire logic freq_out_enable_i,
  input wire logic freq_wave_i,
  output logic interrupt_or_freq_pin_n_o,
  output logic alarm_flag_o
);

  // ==========================================
  // decoding
  function automatic logic in_range(input logic [7:0] addr, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (addr >= lo) && (addr <= hi);
  endfunction

  function automatic logic [2:0] rel_index(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    rel_index = diff[2:0];
  endfunction

  // ==========================================
  // state
  logic [7:0] alarm_reg [RSA_ALARM_BYTES];
  logic [7:0] next_alarm_reg [RSA_ALARM_BYTES];
  logic [7:0] stamp_reg [RSA_STAMP_BYTES];
  logic [7:0] next_stamp_reg [RSA_STAMP_BYTES];
  logic [7:0] cal_now [RSA_ALARM_BYTES];
  logic auto_clear_on_read, next_auto_clear_on_read;
  logic alarm_repeat_select, next_alarm_repeat_select;
  logic alarm_flag, next_alarm_flag;
  logic stamp_taken, next_stamp_taken;
  logic match_prev, next_match_prev;
  logic [RSA_PULSE_WIDTH-1:0] pulse_count, next_pulse_count;
  logic [7:0] rdata, next_rdata;
  logic irq_n, next_irq_n;
  logic batt_sync1, batt_sync2, batt_prev;
  logic match, any_enable, trigger, switchover;

  assign cal_now[0] = cal_seconds_i;
  assign cal_now[1] = cal_minutes_i;
  assign cal_now[2] = cal_hours_i;
  assign cal_now[3] = cal_date_i;
  assign cal_now[4] = cal_month_i;
  assign cal_now[5] = cal_weekday_i;

  // ==========================================
  // alarm compare
  always_comb begin
    match = 1'b1;
    any_enable = 1'b0;
    for (int i = 0; i < RSA_ALARM_BYTES; i++) begin
      if (alarm_reg[i][RSA_ENABLE_BIT]) begin
        any_enable = 1'b1;
        if (alarm_reg[i][6:0] != cal_now[i][6:0]) begin
          match = 1'b0;
        end
      end
    end
    match = match && any_enable;
  end

  // firing only on entry into a match stops a minute-level alarm from
  // retriggering on every second of that minute; entry happens on the
  // 59 to 00 rollover when seconds are not compared
  assign trigger = cal_advance_i && match && !match_prev;
  assign switchover = batt_sync2 && !batt_prev;

  // ==========================================
  // host access decode
  // strobes are one cycle wide, so every decode below acts once per byte
  logic st_write;
  logic st_read;
  logic sc_write;
  logic alarm_write;

  assign st_write = reg_write_i && (reg_addr_i == RSA_STATUS_ADDR);
  assign st_read = reg_read_i && (reg_addr_i == RSA_STATUS_ADDR);
  assign sc_write = reg_write_i && (reg_addr_i == RSA_SUPPLY_CTRL_ADDR);
  assign alarm_write = reg_write_i && in_range(reg_addr_i, RSA_ALARM_BASE, RSA_ALARM_LAST);

  // ==========================================
  // alarm bytes
  always_comb begin
    for (int i = 0; i < RSA_ALARM_BYTES; i++) begin
      next_alarm_reg[i] = alarm_reg[i];
    end
    if (alarm_write) begin
      next_alarm_reg[rel_index(reg_addr_i, RSA_ALARM_BASE)] = reg_wdata_i;
    end
  end

  // ==========================================
  // status bits, alarm flag and match history
  always_comb begin
    next_auto_clear_on_read = auto_clear_on_read;
    next_alarm_repeat_select = alarm_repeat_select;
    if (st_write) begin
      next_auto_clear_on_read = reg_wdata_i[RSA_AUTO_CLEAR_BIT];
      next_alarm_repeat_select = reg_wdata_i[RSA_REPEAT_SELECT_BIT];
    end

    // a trigger in the same cycle as a clear wins
    next_alarm_flag = alarm_flag;
    if (st_write && !reg_wdata_i[RSA_ALARM_FLAG_BIT]) begin
      next_alarm_flag = 1'b0;
    end
    if (st_read && auto_clear_on_read) begin
      next_alarm_flag = 1'b0;
    end
    if (trigger) begin
      next_alarm_flag = 1'b1;
    end

    next_match_prev = match_prev;
    if (cal_advance_i) begin
      next_match_prev = match;
    end
    // a new alarm setting must not inherit the old setting's match, or
    // it would miss its own first match
    if (alarm_write) begin
      next_match_prev = 1'b0;
    end
  end

  // ==========================================
  // repeat pulse and interrupt pin
  always_comb begin
    next_pulse_count = '0;
    if (pulse_count != '0) begin
      next_pulse_count = pulse_count - 1'b1;
    end
    if (trigger && alarm_repeat_select) begin
      next_pulse_count = RSA_PULSE_WIDTH'(PULSE_CYCLES);
    end

    // pin follows the frequency wave when enabled, otherwise the alarm;
    // the repeat pulse ignores the flag entirely
    if (freq_out_enable_i) begin
      next_irq_n = freq_wave_i;
    end else if (alarm_repeat_select) begin
      next_irq_n = (next_pulse_count == '0);
    end else begin
      next_irq_n = !next_alarm_flag;
    end
  end

  // ==========================================
  // supply-loss stamp
  always_comb begin
    // capture wins over a clear in the same cycle
    next_stamp_taken = stamp_taken;
    for (int i = 0; i < RSA_STAMP_BYTES; i++) begin
      next_stamp_reg[i] = stamp_reg[i];
    end
    if (sc_write && reg_wdata_i[RSA_STAMP_CLEAR_BIT]) begin
      next_stamp_taken = 1'b0;
      for (int i = 0; i < RSA_STAMP_BYTES; i++) begin
        next_stamp_reg[i] = RSA_STAMP_RESET;
      end
    end
    if (switchover && !stamp_taken) begin
      next_stamp_taken = 1'b1;
      for (int i = 0; i < RSA_STAMP_BYTES; i++) begin
        next_stamp_reg[i] = cal_now[i];
      end
    end
  end

  // ==========================================
  // read data
  always_comb begin
    next_rdata = rdata;
    if (reg_read_i) begin
      next_rdata = 8'h00;
      if (reg_addr_i == RSA_STATUS_ADDR) begin
        next_rdata[RSA_AUTO_CLEAR_BIT] = auto_clear_on_read;
        next_rdata[RSA_REPEAT_SELECT_BIT] = alarm_repeat_select;
        next_rdata[RSA_ALARM_FLAG_BIT] = alarm_flag;
      end else if (in_range(reg_addr_i, RSA_ALARM_BASE, RSA_ALARM_LAST)) begin
        next_rdata = alarm_reg[rel_index(reg_addr_i, RSA_ALARM_BASE)];
      end else if (in_range(reg_addr_i, RSA_STAMP_BASE, RSA_STAMP_LAST)) begin
        next_rdata = stamp_reg[rel_index(reg_addr_i, RSA_STAMP_BASE)];
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      for (int i = 0; i < RSA_ALARM_BYTES; i++) begin
        alarm_reg[i] <= (i == RSA_DATE_INDEX || i == RSA_MONTH_INDEX) ? RSA_ALARM_DAY_RESET : RSA_ALARM_RESET;
      end
    end else begin
      for (int i = 0; i < RSA_ALARM_BYTES; i++) begin
        alarm_reg[i] <= next_alarm_reg[i];
      end
    end
  end

  // flag and match history reset together so no false entry follows reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      auto_clear_on_read <= 1'b0;
      alarm_repeat_select <= 1'b0;
      alarm_flag <= 1'b0;
      match_prev <= 1'b0;
    end else begin
      auto_clear_on_read <= next_auto_clear_on_read;
      alarm_repeat_select <= next_alarm_repeat_select;
      alarm_flag <= next_alarm_flag;
      match_prev <= next_match_prev;
    end
  end

  // the pin comes from its own flop so no decode glitch reaches it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pulse_count <= '0;
      irq_n <= 1'b1;
    end else begin
      pulse_count <= next_pulse_count;
      irq_n <= next_irq_n;
    end
  end

  // stamp survives everything but reset and an explicit clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stamp_taken <= 1'b0;
      for (int i = 0; i < RSA_STAMP_BYTES; i++) begin
        stamp_reg[i] <= RSA_STAMP_RESET;
      end
    end else begin
      stamp_taken <= next_stamp_taken;
      for (int i = 0; i < RSA_STAMP_BYTES; i++) begin
        stamp_reg[i] <= next_stamp_reg[i];
      end
    end
  end

  // read data holds between reads so a slow host may take it late
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // two flops before anything looks at the battery level, which comes from
  // the supply switch and is not tied to this clock
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      batt_sync1 <= 1'b0;
      batt_sync2 <= 1'b0;
      batt_prev <= 1'b0;
    end else begin
      batt_sync1 <= on_battery_i;
      batt_sync2 <= batt_sync1;
      batt_prev <= batt_sync2;
    end
  end

  assign reg_rdata_o = rdata;
  assign interrupt_or_freq_pin_n_o = irq_n;
  assign alarm_flag_o = alarm_flag;

endmodule
`default_nettype wire

// ==== hw/rsa_pkg.sv ====
package rsa_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] RSA_STATUS_ADDR = 8'h08;
  localparam logic [7:0] RSA_SUPPLY_CTRL_ADDR = 8'h09;
  localparam logic [7:0] RSA_ALARM_BASE = 8'h10;
  localparam logic [7:0] RSA_ALARM_LAST = 8'h15;
  localparam logic [7:0] RSA_STAMP_BASE = 8'h16;
  localparam logic [7:0] RSA_STAMP_LAST = 8'h1A;
  // ==========================================
  // field positions
  localparam int RSA_ENABLE_BIT = 7;
  localparam int RSA_AUTO_CLEAR_BIT = 7;
  localparam int RSA_REPEAT_SELECT_BIT = 6;
  localparam int RSA_ALARM_FLAG_BIT = 4;
  localparam int RSA_STAMP_CLEAR_BIT = 6;
  // ==========================================
  // sizes and reset values
  localparam int RSA_ALARM_BYTES = 6;
  localparam int RSA_STAMP_BYTES = 5;
  localparam logic [7:0] RSA_ALARM_RESET = 8'h00;
  localparam logic [7:0] RSA_ALARM_DAY_RESET = 8'h01;
  localparam logic [7:0] RSA_STAMP_RESET = 8'h00;
  localparam int RSA_DATE_INDEX = 3;
  localparam int RSA_MONTH_INDEX = 4;
  // ==========================================
  // timing
  localparam int RSA_CLOCK_PERIOD_NS = 50;
  localparam int RSA_PULSE_TIME_NS = 100000;
  localparam int RSA_PULSE_CYCLES = (RSA_PULSE_TIME_NS / RSA_CLOCK_PERIOD_NS < 1) ? 1 :
                                    RSA_PULSE_TIME_NS / RSA_CLOCK_PERIOD_NS;
  localparam int RSA_PULSE_WIDTH = 12;
endpackage

// ==== testbench/rsa_alarm_stamp_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// alarm checks
module rsa_alarm_stamp_assertions
  import rsa_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cal_advance_i,
  input wire logic freq_out_enable_i,
  input wire logic freq_wave_i,
  input wire logic interrupt_or_freq_pin_n_o,
  input wire logic alarm_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_rise;
    !freq_out_enable_i ##1 $rose(alarm_flag_o);
  endsequence
  sequence s_auto;
    reg_read_i && reg_addr_i == RSA_STATUS_ADDR && !cal_advance_i ##1 reg_rdata_o[RSA_AUTO_CLEAR_BIT];
  endsequence
  property p_cause;
    $rose(alarm_flag_o) |-> $past(cal_advance_i);
  endproperty
  property p_low;
    s_rise |-> !interrupt_or_freq_pin_n_o;
  endproperty
  property p_clear;
    reg_write_i && reg_addr_i == RSA_STATUS_ADDR && !reg_wdata_i[4] && !cal_advance_i |=> !alarm_flag_o;
  endproperty
  property p_auto;
    s_auto |-> !alarm_flag_o;
  endproperty
  property p_hold;
    alarm_flag_o && !reg_write_i && !reg_read_i |=> alarm_flag_o;
  endproperty
  property p_fall;
    $fell(interrupt_or_freq_pin_n_o) && !$past(freq_out_enable_i) && !$past(freq_out_enable_i, 2) |-> alarm_flag_o;
  endproperty
  property p_wave;
    !$past(reset_i) && $past(freq_out_enable_i) |-> interrupt_or_freq_pin_n_o == $past(freq_wave_i);
  endproperty
  property p_rdata;
    !reg_read_i |=> $stable(reg_rdata_o);
  endproperty
  a_cause: assert property (p_cause) else $error("flag rose alone");
  a_low: assert property (p_low) else $error("pin not low");
  a_clear: assert property (p_clear) else $error("flag not cleared");
  a_auto: assert property (p_auto) else $error("flag not read-cleared");
  a_hold: assert property (p_hold) else $error("flag dropped");
  a_fall: assert property (p_fall) else $error("pin fell alone");
  a_wave: assert property (p_wave) else $error("pin not on wave");
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
bind rsa_alarm_stamp rsa_alarm_stamp_assertions i_rsa_alarm_stamp_assertions (.clock_i(clock_i), .reset_i(reset_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .cal_advance_i(cal_advance_i), .freq_out_enable_i(freq_out_enable_i),
  .freq_wave_i(freq_wave_i), .interrupt_or_freq_pin_n_o(interrupt_or_freq_pin_n_o), .alarm_flag_o(alarm_flag_o));
`default_nettype wire

// ==== testbench/rsa_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// host side; released lines show the inverse so stale data never looks valid
module rsa_host (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_write_o,
  output logic reg_read_o
);
  initial begin
    {reg_addr_o, reg_wdata_o, reg_write_o, reg_read_o} = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {reg_addr_o, reg_wdata_o, reg_write_o} = {a, d, 1'h1};
    @(negedge clock_i);
    {reg_addr_o, reg_wdata_o, reg_write_o} = {~a, ~d, 1'h0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    {reg_addr_o, reg_read_o} = {a, 1'h1};
    @(negedge clock_i);
    {reg_addr_o, reg_read_o} = {~a, 1'h0};
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_rsa_alarm_stamp.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_rsa_alarm_stamp
  import rsa_pkg::*;
();
  logic clk, rst, adv, bat, fe, fw, irq_n, flag, ws, rs;
  logic [7:0] addr, wd, rdata, sec, min;
  int n_mismatch, total_checks;
  rsa_alarm_stamp #(.PULSE_CYCLES(4)) i_rsa_alarm_stamp (.clock_i(clk), .reset_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(ws), .reg_read_i(rs), .reg_rdata_o(rdata), .cal_seconds_i(sec),
    .cal_minutes_i(min), .cal_hours_i(8'h11), .cal_date_i(8'h01), .cal_month_i(8'h01), .cal_weekday_i(8'h00),
    .cal_advance_i(adv), .on_battery_i(bat), .freq_out_enable_i(fe), .freq_wave_i(fw), .interrupt_or_freq_pin_n_o(irq_n),
    .alarm_flag_o(flag));
  rsa_host i_rsa_host (.clock_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wd),
    .reg_write_o(ws), .reg_read_o(rs));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_rsa_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic tick(input logic [7:0] s, input logic [7:0] m);
    @(negedge clk);
    {sec, min, adv} = {s, m, 1'h1};
    @(negedge clk);
    adv = 1'h0;
  endtask
  // ==========
  // expected pin pair is {irq_n, flag}
  task automatic pin(input logic [1:0] exp);
    chk({6'h00, irq_n, flag}, {6'h00, exp});
  endtask
  initial begin
    {rst, adv, bat, fe, fw, sec, min} = 21'h100000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < 12; i++) rchk(RSA_ALARM_BASE + 8'(i), (i == 3 || i == 4) ? 8'h01 : 8'h00);
    tick(8'h30, 8'h30);
    pin(2'h2);
    i_rsa_host.wr(8'h11, 8'hB0);
    i_rsa_host.wr(8'h12, 8'h92);
    tick(8'h00, 8'h30);
    pin(2'h2);
    i_rsa_host.wr(8'h12, 8'h91);
    tick(8'h59, 8'h29);
    pin(2'h2);
    tick(8'h00, 8'h30);
    pin(2'h1);
    i_rsa_host.wr(8'h08, 8'h00);
    pin(2'h2);
    i_rsa_host.wr(8'h08, 8'h80);
    tick(8'h00, 8'h31);
    tick(8'h00, 8'h30);
    rchk(8'h08, 8'h90);
    pin(2'h2);
    i_rsa_host.wr(8'h08, 8'h40);
    i_rsa_host.wr(8'h11, 8'h00);
    i_rsa_host.wr(8'h10, 8'hB0);
    tick(8'h30, 8'h31);
    pin(2'h1);
    repeat (3) @(negedge clk);
    pin(2'h1);
    @(negedge clk);
    pin(2'h3);
    i_rsa_host.wr(8'h08, 8'h40);
    tick(8'h31, 8'h31);
    tick(8'h30, 8'h31);
    pin(2'h1);
    {fe, fw} = 2'h3;
    @(negedge clk);
    pin(2'h3);
    repeat (2) @(negedge clk);
    {fe, fw} = 2'h0;
    tick(8'h12, 8'h34);
    bat = 1'h1;
    repeat (5) @(negedge clk);
    tick(8'h13, 8'h35);
    bat = 1'h0;
    repeat (3) @(negedge clk);
    bat = 1'h1;
    repeat (5) @(negedge clk);
    rchk(8'h16, 8'h12);
    rchk(8'h17, 8'h34);
    rchk(8'h1A, 8'h01);
    i_rsa_host.wr(8'h09, 8'h40);
    rchk(8'h16, 8'h00);
    end_sim;
  end
  // the run needs some 100 cycles; 2000 leaves ample room
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
